/* File: adc_cfg_pkg.sv */
// Register map, field positions, pattern constants and carrier types of the
// output configuration bank. Assumes a single design file importing it all.
package adc_cfg_pkg;
    localparam int NUM_REGS = 34;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam logic [13:0] REG_ADDR [NUM_REGS] = '{
        14'h0001, 14'h0003, 14'h0004, 14'h0005, 14'h0006, 14'h0007, 14'h0009, 14'h000A,
        14'h000B, 14'h000E, 14'h000F, 14'h0013, 14'h0015, 14'h0025, 14'h0027, 14'h011D,
        14'h0122, 14'h0134, 14'h0139, 14'h021D, 14'h0222, 14'h0234, 14'h0239, 14'h0308,
        14'h041D, 14'h0422, 14'h0434, 14'h0439, 14'h051D, 14'h0522, 14'h0534, 14'h0539,
        14'h0608, 14'h070A};
    // Bits that store; the soft reset bit is left out so it never sticks
    localparam logic [7:0] REG_WMASK [NUM_REGS] = '{
        8'hFF, 8'h01, 8'h01, 8'h01, 8'h02, 8'h01, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFC, 8'h03,
        8'hFD, 8'hFF, 8'hC0, 8'h02, 8'h02, 8'h28, 8'h08, 8'h02, 8'h02, 8'h28, 8'h08, 8'hC0,
        8'h02, 8'h02, 8'h28, 8'h08, 8'h02, 8'h02, 8'h28, 8'h08, 8'hC0, 8'h01};
    // Write-only fields read back as zero
    localparam logic [7:0] REG_RMASK [NUM_REGS] = '{
        8'hFF, 8'h01, 8'h01, 8'h01, 8'h02, 8'h01, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFC, 8'h03,
        8'h6D, 8'hFF, 8'hC0, 8'h02, 8'h02, 8'h28, 8'h08, 8'h02, 8'h02, 8'h28, 8'h08, 8'h00,
        8'h02, 8'h02, 8'h28, 8'h08, 8'h02, 8'h02, 8'h28, 8'h08, 8'hC0, 8'h01};
    localparam int SLOT_DITHER = 0, SLOT_ORDER = 1, SLOT_SWAP = 2, SLOT_LANES = 3;
    localparam int SLOT_PATEN = 4, SLOT_OVR = 5, SLOT_FMT = 6, SLOT_PAT_AB = 7;
    localparam int SLOT_PAT_CD = 8, SLOT_USER_HI = 9, SLOT_USER_LO = 10, SLOT_LOWRATE = 11;
    localparam int SLOT_POWER = 12, SLOT_SWING = 13, SLOT_CLKDIV = 14, SLOT_HIF_54 = 23;
    localparam int SLOT_HIF_76 = 32, SLOT_SYSREF = 33;
    localparam int CHOP_SLOT [4] = '{16, 25, 29, 20};
    localparam int DITH_SLOT [4] = '{17, 26, 30, 21};
    localparam int PERF_SLOT [4] = '{18, 27, 31, 22};
    localparam int HIF_SLOT [4] = '{15, 19, 24, 28};
    localparam int PAT_EN_BIT = 1, SOFT_RST_BIT = 0, ALIGN_BIT = 1, CODING_BIT = 0;
    localparam int STANDBY_BIT = 3, GLOBAL_BIT = 2, PIN_FUNC_BIT = 0;
    localparam int DITH_HI_BIT = 5, DITH_LO_BIT = 3, CHOP_BIT = 1, PERF_BIT = 3, HIF_BIT = 1;
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam logic [4:0] ADDR_LAST = 5'h0F;
    localparam logic [3:0] PAT_NORMAL = 4'h0, PAT_ZEROS = 4'h1, PAT_ONES = 4'h2;
    localparam logic [3:0] PAT_TOGGLE = 4'h3, PAT_RAMP = 4'h4, PAT_USER = 4'h5;
    localparam logic [3:0] PAT_DESKEW = 4'h6, PAT_PRBS = 4'h8, PAT_SINE = 4'h9;
    localparam logic [13:0] TOGGLE_A = 14'h0AAA, TOGGLE_B = 14'h0555;
    localparam logic [13:0] DESKEW_WORD = 14'h2AAA, ALL_ONES = 14'h3FFF;
    localparam logic [13:0] SINE_TABLE [8] = '{14'h0000, 14'h095F, 14'h2000, 14'h36A0,
        14'h3FFF, 14'h36A0, 14'h2000, 14'h095F};
    localparam logic [14:0] PRBS_SEED = 15'h7FFF;
    typedef struct packed {
        logic [13:0] lane0;
        logic [6:0]  lane1;
    } lane_word_t;
    typedef struct packed {
        logic [3:0] chanSleep;
        logic       chipSleep;
        logic       chipStandby;
        logic [3:0] ditherOff;
        logic [3:0] chopOff;
        logic [3:0] perfMode;
        logic [7:0] highIf;
        logic [1:0] clkDiv;
        logic [7:0] swing;
        logic [1:0] lowRate;
        logic       sysrefSleep;
    } analog_ctrl_t;
endpackage

/* File: adc_output_config_regs.sv */
// Serial-programmed configuration bank and output formatter of the converter.
// Assumes the converter core delivers offset-binary samples on sys_clk and
// that the serial clock only moves while the select line is low.
module adc_output_config_regs
(
    input  wire logic                         sys_clk,
    input  wire logic                         reset,
    input  wire logic                         spiClk,
    input  wire logic                         serialSelectN,
    input  wire logic                         serialIn,
    output logic                              serialOut,
    output logic                              serialOutOeN,
    input  wire logic                         sleepPin,
    input  wire logic [3:0][13:0]             sampleIn,
    input  wire logic [3:0]                   overrangeIn,
    output adc_cfg_pkg::lane_word_t [3:0]     laneWord,
    output adc_cfg_pkg::analog_ctrl_t         analogCtrl
);
    import adc_cfg_pkg::*;

    logic [4:0]  bitCnt_q, bitCnt_d;
    logic [22:0] shift_q, shift_d;
    logic [7:0]  rdShift_q, rdShift_d;
    logic        isRead_q, isRead_d;
    logic        wrTgl_q, wrTgl_d;
    logic [7:0]  regFile_q [NUM_REGS];
    logic [7:0]  regFile_d [NUM_REGS];
    logic        sdo_d, sdoOeN_d;
    logic        frameRst;
    logic [2:0]  wrSync_q, wrSync_d;
    logic [1:0]  sleepSync_q, sleepSync_d;
    logic [7:0]  cfg_q [NUM_REGS];
    logic [7:0]  cfg_d [NUM_REGS];
    logic [13:0] ramp_q [4];
    logic [13:0] ramp_d [4];
    logic [14:0] prbs_q [4];
    logic [14:0] prbs_d [4];
    logic [3:0]  sel [4];
    logic [3:0][13:0] chanWord;
    lane_word_t [3:0] laneWord_d;
    analog_ctrl_t analog_d;
    logic        copyEv, patEn, align, twoLane, oddEven, swap;

    // Address lookup: hit flag and slot index
    function automatic logic [6:0] slotOf(input logic [13:0] a);
        slotOf = 7'h00;
        for (int i = 0; i < NUM_REGS; i++)
        begin
            if (REG_ADDR[i] == a)
                slotOf = {1'b1, 6'(i)};
        end
    endfunction

    // Pattern select nibble of one channel
    function automatic logic [3:0] chanSel(input logic [7:0] ab, input logic [7:0] cd,
                                           input int ch);
        case (ch)
            0:       chanSel = ab[7:4];
            1:       chanSel = ab[3:0];
            2:       chanSel = cd[7:4];
            default: chanSel = cd[3:0];
        endcase
    endfunction

    // Frame logic is cleared whenever the select line is high
    assign frameRst = reset | serialSelectN;

    // Frame shifter, bit count and readback byte
    always_comb
    begin
        logic [6:0] rs;
        rs = slotOf({shift_q[12:0], serialIn});
        bitCnt_d = (bitCnt_q == FRAME_LAST) ? 5'h00 : bitCnt_q + 5'h01;
        shift_d = {shift_q[21:0], serialIn};
        isRead_d = (bitCnt_q == 5'h00) ? serialIn : isRead_q;
        rdShift_d = {rdShift_q[6:0], 1'b0};
        if (bitCnt_q == ADDR_LAST)
            rdShift_d = rs[6] ? (regFile_q[rs[5:0]] & REG_RMASK[rs[5:0]]) : 8'h00;
    end

    always_ff @(posedge spiClk or posedge frameRst)
    begin
        if (frameRst)
        begin
            bitCnt_q <= 5'h00;
            shift_q <= 23'h000000;
            isRead_q <= 1'b0;
            rdShift_q <= 8'h00;
        end
        else
        begin
            bitCnt_q <= bitCnt_d;
            shift_q <= shift_d;
            isRead_q <= isRead_d;
            rdShift_q <= rdShift_d;
        end
    end

    // Readback drives on the falling edge so the controller samples mid-bit
    always_comb
    begin
        sdo_d = rdShift_q[7];
        sdoOeN_d = !(isRead_q && bitCnt_q[4]);
    end

    always_ff @(negedge spiClk or posedge frameRst)
    begin
        if (frameRst)
        begin
            serialOut <= 1'b0;
            serialOutOeN <= 1'b1;
        end
        else
        begin
            serialOut <= sdo_d;
            serialOutOeN <= sdoOeN_d;
        end
    end

    // Register file: loaded on the 24th edge of a write frame
    always_comb
    begin
        logic [6:0] ws;
        logic [7:0] wd;
        ws = slotOf(shift_q[20:7]);
        wd = {shift_q[6:0], serialIn};
        regFile_d = regFile_q;
        wrTgl_d = wrTgl_q;
        if (bitCnt_q == FRAME_LAST && !shift_q[22])
        begin
            wrTgl_d = !wrTgl_q;
            if (ws[6] && ws[5:0] == 6'(SLOT_PATEN) && wd[SOFT_RST_BIT])
            begin
                for (int i = 0; i < NUM_REGS; i++)
                    regFile_d[i] = RESET_VAL;
            end
            else if (ws[6])
                regFile_d[ws[5:0]] = wd & REG_WMASK[ws[5:0]];
        end
    end

    always_ff @(posedge spiClk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < NUM_REGS; i++)
                regFile_q[i] <= RESET_VAL;
            wrTgl_q <= 1'b0;
        end
        else
        begin
            regFile_q <= regFile_d;
            wrTgl_q <= wrTgl_d;
        end
    end

    // Write event toggle and sleep pin are synchronised into sys_clk; the
    // file itself is copied only after the toggle arrives, when it is stable
    always_comb
    begin
        wrSync_d = {wrSync_q[1:0], wrTgl_q};
        sleepSync_d = {sleepSync_q[0], sleepPin};
        copyEv = wrSync_q[1] ^ wrSync_q[2];
        cfg_d = cfg_q;
        if (copyEv)
            cfg_d = regFile_q;
    end

    // Pattern generators and output formatting
    always_comb
    begin
        logic [13:0] baseRamp;
        logic [14:0] baseLfsr;
        logic [13:0] norm;
        logic [6:0]  l0;
        logic [6:0]  l1;
        logic        restart;
        patEn = cfg_q[SLOT_PATEN][PAT_EN_BIT];
        align = cfg_q[SLOT_FMT][ALIGN_BIT];
        twoLane = !cfg_q[SLOT_LANES][0];
        oddEven = cfg_q[SLOT_ORDER][0];
        swap = cfg_q[SLOT_SWAP][0];
        baseRamp = 14'h0000;
        baseLfsr = PRBS_SEED;
        norm = 14'h0000;
        l0 = 7'h00;
        l1 = 7'h00;
        restart = 1'b0;
        for (int ch = 0; ch < 4; ch++)
        begin
            sel[ch] = chanSel(cfg_q[SLOT_PAT_AB], cfg_q[SLOT_PAT_CD], ch);
            restart = copyEv &&
                (chanSel(regFile_q[SLOT_PAT_AB], regFile_q[SLOT_PAT_CD], ch) != sel[ch]);
            // Aligned channels all follow channel A's sequence
            baseRamp = align ? ramp_q[0] : ramp_q[ch];
            baseLfsr = align ? prbs_q[0] : prbs_q[ch];
            ramp_d[ch] = restart ? 14'h0000 : baseRamp + 14'h0001;
            prbs_d[ch] = restart ? PRBS_SEED : {baseLfsr[13:0], baseLfsr[14] ^ baseLfsr[13]};
            norm = cfg_q[SLOT_FMT][CODING_BIT] ? sampleIn[ch] :
                   {~sampleIn[ch][13], sampleIn[ch][12:0]};
            if (cfg_q[SLOT_OVR][0])
                norm[0] = overrangeIn[ch];
            if (!patEn)
                chanWord[ch] = norm;
            else
            begin
                case (sel[ch])
                    PAT_NORMAL: chanWord[ch] = norm;
                    PAT_ZEROS:  chanWord[ch] = 14'h0000;
                    PAT_ONES:   chanWord[ch] = ALL_ONES;
                    PAT_TOGGLE: chanWord[ch] = ramp_q[ch][0] ? TOGGLE_B : TOGGLE_A;
                    PAT_RAMP:   chanWord[ch] = ramp_q[ch];
                    PAT_USER:   chanWord[ch] = {cfg_q[SLOT_USER_HI],
                                                cfg_q[SLOT_USER_LO][7:2]};
                    PAT_DESKEW: chanWord[ch] = DESKEW_WORD;
                    PAT_PRBS:   chanWord[ch] = prbs_q[ch][13:0];
                    PAT_SINE:   chanWord[ch] = SINE_TABLE[ramp_q[ch][2:0]];
                    default:    chanWord[ch] = 14'h0000;
                endcase
            end
            // Lane split: halves or interleaved bits
            for (int b = 0; b < 7; b++)
            begin
                l0[b] = oddEven ? chanWord[ch][2 * b] : chanWord[ch][b];
                l1[b] = oddEven ? chanWord[ch][2 * b + 1] : chanWord[ch][b + 7];
            end
            if (!twoLane)
            begin
                laneWord_d[ch].lane0 = chanWord[ch];
                laneWord_d[ch].lane1 = 7'h00;
            end
            else if (swap)
            begin
                laneWord_d[ch].lane0 = {7'h00, l1};
                laneWord_d[ch].lane1 = l0;
            end
            else
            begin
                laneWord_d[ch].lane0 = {7'h00, l0};
                laneWord_d[ch].lane1 = l1;
            end
        end
    end

    // Analog control decode; pin level is used only after synchronising
    always_comb
    begin
        logic pinHigh;
        pinHigh = sleepSync_q[1];
        analog_d.chanSleep = cfg_q[SLOT_POWER][7:4];
        analog_d.chipSleep = cfg_q[SLOT_POWER][GLOBAL_BIT] ||
                             (pinHigh && !cfg_q[SLOT_POWER][PIN_FUNC_BIT]);
        analog_d.chipStandby = cfg_q[SLOT_POWER][STANDBY_BIT] ||
                               (pinHigh && cfg_q[SLOT_POWER][PIN_FUNC_BIT]);
        for (int ch = 0; ch < 4; ch++)
        begin
            analog_d.ditherOff[3 - ch] = (cfg_q[SLOT_DITHER][7 - 2 * ch -: 2] == 2'h3) &&
                cfg_q[DITH_SLOT[ch]][DITH_HI_BIT] && cfg_q[DITH_SLOT[ch]][DITH_LO_BIT];
            analog_d.chopOff[3 - ch] = cfg_q[CHOP_SLOT[ch]][CHOP_BIT];
            analog_d.perfMode[3 - ch] = cfg_q[PERF_SLOT[ch]][PERF_BIT];
            analog_d.highIf[ch] = cfg_q[HIF_SLOT[ch]][HIF_BIT];
        end
        analog_d.highIf[5:4] = cfg_q[SLOT_HIF_54][7:6];
        analog_d.highIf[7:6] = cfg_q[SLOT_HIF_76][7:6];
        analog_d.clkDiv = cfg_q[SLOT_CLKDIV][7:6];
        analog_d.swing = cfg_q[SLOT_SWING];
        analog_d.lowRate = cfg_q[SLOT_LOWRATE][1:0];
        analog_d.sysrefSleep = cfg_q[SLOT_SYSREF][0];
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            wrSync_q <= 3'h0;
            sleepSync_q <= 2'h0;
            for (int i = 0; i < NUM_REGS; i++)
                cfg_q[i] <= RESET_VAL;
            for (int ch = 0; ch < 4; ch++)
            begin
                ramp_q[ch] <= 14'h0000;
                prbs_q[ch] <= PRBS_SEED;
            end
            laneWord <= '0;
            analogCtrl <= '0;
        end
        else
        begin
            wrSync_q <= wrSync_d;
            sleepSync_q <= sleepSync_d;
            cfg_q <= cfg_d;
            ramp_q <= ramp_d;
            prbs_q <= prbs_d;
            laneWord <= laneWord_d;
            analogCtrl <= analog_d;
        end
    end

    // Checks on the serial side
    chk_frame_write: assert property (@(posedge spiClk) disable iff (reset)
        (bitCnt_q == FRAME_LAST && !shift_q[22] && shift_q[20:7] == 14'h0001)
        |=> regFile_q[SLOT_DITHER] == $past({shift_q[6:0], serialIn}))
        else $error("write frame did not load register");
    chk_soft_reset: assert property (@(posedge spiClk) disable iff (reset)
        (bitCnt_q == FRAME_LAST && !shift_q[22] && shift_q[20:7] == 14'h0006 && serialIn)
        |=> regFile_q[SLOT_PATEN] == 8'h00 && regFile_q[SLOT_PAT_AB] == 8'h00
        && regFile_q[SLOT_ORDER] == 8'h00)
        else $error("soft reset left register contents");
    // Readback line is driven only in the data byte (bit counts 16 to 23) of a read frame
    chk_read_drive: assert property (@(posedge spiClk) disable iff (reset)
        (isRead_q && bitCnt_q[4]) |-> !serialOutOeN)
        else $error("readback not driven");
    chk_write_quiet: assert property (@(posedge spiClk) disable iff (reset)
        !isRead_q |-> serialOutOeN)
        else $error("readback driven in write frame");

    // Checks on the output side
    chk_one_lane: assert property (@(posedge sys_clk) disable iff (reset)
        !twoLane |=> laneWord[0].lane0 == $past(chanWord[0]) && laneWord[0].lane1 == 7'h00)
        else $error("one-lane word wrong");
    chk_odd_even: assert property (@(posedge sys_clk) disable iff (reset)
        (twoLane && !swap && oddEven) |=> laneWord[2].lane0[0] == $past(chanWord[2][0])
        && laneWord[2].lane1[0] == $past(chanWord[2][1]))
        else $error("even/odd lane split wrong");
    chk_lane_swap: assert property (@(posedge sys_clk) disable iff (reset)
        (twoLane && swap && !oddEven) |=> laneWord[3].lane0[6:0] == $past(chanWord[3][13:7]))
        else $error("lane swap wrong");
    chk_coding_ovr: assert property (@(posedge sys_clk) disable iff (reset)
        (!patEn && !cfg_q[SLOT_FMT][CODING_BIT] && cfg_q[SLOT_OVR][0]) |->
        chanWord[1] == {~sampleIn[1][13], sampleIn[1][12:1], overrangeIn[1]})
        else $error("coding or overrange bit wrong");
    chk_deskew_word: assert property (@(posedge sys_clk) disable iff (reset)
        (patEn && sel[2] == PAT_DESKEW) |-> chanWord[2] == 14'h2AAA)
        else $error("deskew word wrong");
    // Toggle words are complements of each other within the low twelve bits
    chk_toggle_pair: assert property (@(posedge sys_clk) disable iff (reset)
        (patEn && sel[0] == PAT_TOGGLE && !copyEv) ##1 (patEn && sel[0] == PAT_TOGGLE)
        |-> chanWord[0] == ($past(chanWord[0]) ^ 14'h0FFF))
        else $error("toggle words not complementary");
    chk_prbs_shift: assert property (@(posedge sys_clk) disable iff (reset)
        (!copyEv && !align) |=> prbs_q[1][14:1] == $past(prbs_q[1][13:0]))
        else $error("pseudo-random sequence did not shift");
    chk_normal_data: assert property (@(posedge sys_clk) disable iff (reset)
        (!patEn && cfg_q[SLOT_FMT][CODING_BIT] && !cfg_q[SLOT_OVR][0])
        |-> chanWord[0] == sampleIn[0])
        else $error("normal data not passed through");
    chk_ramp_step: assert property (@(posedge sys_clk) disable iff (reset)
        (!copyEv && !align) |=> ramp_q[1] == $past(ramp_q[1]) + 14'h0001)
        else $error("ramp did not step by one");
    chk_sine_seq: assert property (@(posedge sys_clk) disable iff (reset)
        (patEn && sel[1] == PAT_SINE && ramp_q[1] == 14'h0004 && !copyEv && !align)
        ##1 (sel[1] == PAT_SINE && patEn) |-> chanWord[1] == 14'h36A0)
        else $error("sine sequence wrong");
    chk_align_lock: assert property (@(posedge sys_clk) disable iff (reset)
        (align && !copyEv) |=> ramp_q[3] == ramp_q[0] && prbs_q[2] == prbs_q[0])
        else $error("aligned patterns diverged");
    chk_sleep_pin: assert property (@(posedge sys_clk) disable iff (reset)
        (sleepPin && !cfg_q[SLOT_POWER][PIN_FUNC_BIT] && !copyEv) [*3] |=> analogCtrl.chipSleep)
        else $error("sleep pin did not force sleep");
    chk_dither_off: assert property (@(posedge sys_clk) disable iff (reset)
        ##1 analogCtrl.ditherOff[3] == $past(cfg_q[SLOT_DITHER][7:6] == 2'h3 &&
        cfg_q[DITH_SLOT[0]][DITH_HI_BIT] && cfg_q[DITH_SLOT[0]][DITH_LO_BIT]))
        else $error("dither disable decode wrong");
endmodule

/* File: spi_host_model.sv */
// Controller model: serial programming host of the configuration bank.
// Assumes the bank samples serialIn on rising spiClk while select is low.
module spi_host_model
(
    output logic      spiClk,
    output logic      serialSelectN,
    output logic      serialIn,
    input  wire logic serialOut,
    input  wire logic serialOutOeN
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle: select high, clock parked low between frames
    initial
    begin
        spiClk = 1'b0;
        serialSelectN = 1'b0;
        serialIn = 1'b0;
        // One rising select edge clears the frame logic before any frame
        #3;
        serialSelectN = 1'b1;
    end

    // One whole frame at a 32 ns period; the last eight bits are captured before
    // each rising edge, when the device has had half a period to present them
    task automatic xfer(input logic rw, input logic [13:0] addr, input logic [7:0] din,
                        output logic [7:0] dout);
        logic [23:0] bits;
        bits = {rw, 1'b1, addr, din};
        dout = 8'h00;
        #7;
        serialSelectN = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            serialIn = bits[i];
            #16;
            if (i < 8)
                dout = {dout[6:0], serialOutOeN ? ~serialOut : serialOut}; // Undriven reads inverted
            spiClk = 1'b1;
            #16;
            spiClk = 1'b0;
        end
        #16;
        serialSelectN = 1'b1;
        serialIn = ~serialIn; // Released line must not keep its last level
    endtask
endmodule

/* File: testbench.sv */
// Self-checking bench of the output configuration bank.
// Assumes the controller model above and one shared 14-bit sample on all channels.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_cfg_pkg::*;

    logic             sys_clk = 1'b0;
    logic             reset = 1'b0;
    logic             spiClk, serialSelectN, serialIn, serialOut, serialOutOeN;
    logic             sleepPin = 1'b0;
    logic [3:0][13:0] sampleIn = '0;
    logic [3:0]       overrangeIn = '0;
    lane_word_t [3:0] laneWord;
    analog_ctrl_t     analogCtrl;
    int               errors = 0;
    int               checks = 0;
    logic [7:0]       rd;
    logic [13:0]      w [9];

    always #12.5 sys_clk = ~sys_clk;

    spi_host_model i_spi_host_model (.spiClk(spiClk), .serialSelectN(serialSelectN),
        .serialIn(serialIn), .serialOut(serialOut), .serialOutOeN(serialOutOeN));
    adc_output_config_regs i_adc_output_config_regs (.sys_clk(sys_clk), .reset(reset),
        .spiClk(spiClk), .serialSelectN(serialSelectN), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutOeN(serialOutOeN), .sleepPin(sleepPin),
        .sampleIn(sampleIn), .overrangeIn(overrangeIn), .laneWord(laneWord),
        .analogCtrl(analogCtrl));

    task automatic summarize;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Write, then leave time for the copy into the core clock domain
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        i_spi_host_model.xfer(1'b0, a, d, rd);
        repeat (8) @(negedge sys_clk);
    endtask

    task automatic rdchk(input logic [13:0] a, input logic [7:0] exp);
        i_spi_host_model.xfer(1'b1, a, 8'h00, rd);
        chk("readback", {13'h0, exp}, {13'h0, rd});
        chk("readback release", 21'h1, {20'h0, serialOutOeN});
    endtask

    // Expected lanes; m = {one lane, swap, even/odd}
    function automatic lane_word_t fmt(input logic [13:0] v, input logic [2:0] m);
        lane_word_t r;
        logic [6:0] a, b;
        for (int i = 0; i < 7; i++)
        begin
            a[i] = m[0] ? v[2*i] : v[i];
            b[i] = m[0] ? v[2*i+1] : v[i+7];
        end
        r = '0;
        if (m[2])
            r.lane0 = v;
        else
            r = m[1] ? {7'h00, b, a} : {7'h00, a, b};
        return r;
    endfunction

    task automatic test_regs;
        logic [13:0] adr [7] = '{14'h3, 14'hA, 14'hF, 14'h13, 14'h15, 14'h27, 14'h2};
        logic [7:0]  dat [7] = '{8'h01, 8'h5A, 8'hFC, 8'h02, 8'hFD, 8'hC0, 8'hFF};
        logic [7:0]  exp [7] = '{8'h01, 8'h5A, 8'hFC, 8'h02, 8'h6D, 8'hC0, 8'h00};
        for (int i = 0; i < 7; i++)
            rdchk(adr[i], 8'h00);
        for (int i = 0; i < 7; i++)
            wr(adr[i], dat[i]);
        for (int i = 0; i < 7; i++)
            rdchk(adr[i], exp[i]);
        chk("sleep", 21'h3F, {15'h0, analogCtrl.chanSleep, analogCtrl.chipSleep,
            analogCtrl.chipStandby});
        chk("rate div", 21'hE, {17'h0, analogCtrl.clkDiv, analogCtrl.lowRate});
        wr(14'h6, 8'h01);
        for (int i = 0; i < 7; i++)
            rdchk(adr[i], 8'h00);
        rdchk(14'h6, 8'h00);
    endtask

    task automatic test_lanes;
        @(negedge sys_clk);
        sampleIn = {4{14'h2345}};
        overrangeIn = 4'hF;
        for (int m = 0; m < 8; m++)
        begin
            wr(14'h3, {7'h0, m[0]});
            wr(14'h4, {7'h0, m[1]});
            wr(14'h5, {7'h0, m[2]});
            chk("lanes", fmt(14'h0345, m[2:0]), laneWord[0]);
        end
        wr(14'h9, 8'h01);
        chk("offset", fmt(14'h2345, 3'h7), laneWord[0]);
        wr(14'h7, 8'h01);
        chk("ovr", fmt(14'h2345, 3'h7), laneWord[0]);
        overrangeIn = 4'h0;
        @(negedge sys_clk);
        @(negedge sys_clk);
        chk("ovr", fmt(14'h2344, 3'h7), laneWord[0]);
        wr(14'h9, 8'h00);
        chk("ovr twos", fmt(14'h0344, 3'h7), laneWord[0]);
        wr(14'h6, 8'h01);
    endtask

    task automatic seqchk(input logic [3:0] c);
        logic [13:0] s [8] = '{14'd0, 14'd2399, 14'd8192, 14'd13984, 14'd16383,
            14'd13984, 14'd8192, 14'd2399};
        logic ok, hit;
        wr(14'hA, {c, c});
        wr(14'hB, {c, c});
        for (int i = 0; i < 9; i++)
        begin
            @(negedge sys_clk);
            w[i] = laneWord[3].lane0;
        end
        hit = 1'b0;
        for (int r = 0; r < 8; r++)
        begin
            ok = 1'b1;
            for (int i = 0; i < 9; i++)
                ok = ok && (c == 4'h9 ? w[i] === s[(r+i)%8] : c == 4'h4 ?
                    (i == 0 || w[i] === w[i-1] + 14'h1) : c == 4'h3 ?
                    (w[i] === (r[0] ^ i[0] ? 14'h0AAA : 14'h0555)) :
                    (i == 0 || w[i][13:1] === w[i-1][12:0]));
            hit = hit | ok;
        end
        chk("sequence", 21'h1, {20'h0, hit});
    endtask

    task automatic test_patterns;
        wr(14'h5, 8'h01);
        wr(14'hE, 8'hAB);
        wr(14'hF, 8'hCC);
        wr(14'h6, 8'h02);
        wr(14'hA, 8'h12);
        wr(14'hB, 8'h65);
        chk("chan a", 21'h0, laneWord[0]);
        chk("chan b", {14'h3FFF, 7'h0}, laneWord[1]);
        chk("chan c", {14'h2AAA, 7'h0}, laneWord[2]);
        chk("chan d", {14'h2AF3, 7'h0}, laneWord[3]);
        seqchk(4'h3);
        seqchk(4'h4);
        seqchk(4'h9);
        seqchk(4'h8);
        wr(14'h9, 8'h02);
        seqchk(4'h4);
        chk("aligned", laneWord[3], laneWord[0]);
        wr(14'h6, 8'h00);
        chk("normal", fmt(14'h0345, 3'h7), laneWord[0]);
        wr(14'h6, 8'h01);
    endtask

    task automatic test_power;
        wr(14'h1, 8'hC0);
        chk("dither", 21'h0, {17'h0, analogCtrl.ditherOff});
        wr(14'h134, 8'h28);
        chk("dither", 21'h8, {17'h0, analogCtrl.ditherOff});
        sleepPin = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk("pin", 21'h2, {19'h0, analogCtrl.chipSleep, analogCtrl.chipStandby});
        wr(14'h15, 8'h01);
        chk("pin", 21'h1, {19'h0, analogCtrl.chipSleep, analogCtrl.chipStandby});
        sleepPin = 1'b0;
    endtask

    // Main sequence: reset, then each scenario in turn
    initial
    begin
        // Raised on a falling edge so the link-side flops see a clearing edge
        @(negedge sys_clk);
        reset = 1'b1;
        repeat (20) @(negedge sys_clk);
        reset = 1'b0;
        test_regs();
        test_lanes();
        test_patterns();
        test_power();
        summarize();
    end

    // Watchdog well beyond the roughly 77 us the scenarios need
    initial
    begin
        #1ms;
        errors++;
        summarize();
    end
endmodule
